// ===== pkg/isos_pkg.sv
package isos_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OV_WARN   = 8'h57;
  localparam logic [7:0] CMD_UV_WARN   = 8'h58;
  localparam logic [7:0] CMD_UV_FLT    = 8'h59;
  localparam logic [7:0] CMD_UV_ACT    = 8'h5a;
  localparam logic [7:0] CMD_PG_ON     = 8'h5e;
  localparam logic [7:0] CMD_TON_DLY   = 8'h60;
  localparam logic [7:0] CMD_TURN_ON_RAMP_TIME  = 8'h61;
  localparam logic [7:0] CMD_TOFF_DLY  = 8'h64;
  localparam logic [7:0] CMD_TURN_OFF_RAMP_TIME = 8'h65;

  // ----------------------------------------------------------------
  // Fault action fields
  // ----------------------------------------------------------------
  localparam int         RESP_HI       = 7;
  localparam int         RESP_LO       = 6;
  localparam int         RETRY_HI      = 5;
  localparam int         RETRY_LO      = 3;
  localparam int         RTIME_HI      = 2;
  localparam int         RTIME_LO      = 0;
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam int         RETRY_UNIT_MS = 35;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_OV_WARN = 16'h03ff;
  localparam logic [15:0] RST_UV_WARN = 16'h0000;
  localparam logic [15:0] RST_UV_FLT  = 16'h0000;
  localparam logic [7:0]  RST_UV_ACT  = 8'h80;
  localparam logic [15:0] RST_PG_ON   = 16'h0000;
  localparam logic [15:0] RST_TIME    = 16'h0000;
  localparam int          MS_NS       = 1000000;
  localparam int          CLK_NS      = 10;
  localparam int          MS_CYCLES_DEF = MS_NS / CLK_NS;

  // Sequencer states, Gray along the on/off path except ST_FALL back to ST_OFF
  typedef enum logic [2:0] {
    ST_OFF     = 3'h0,
    ST_ON_DLY  = 3'h1,
    ST_RISE    = 3'h3,
    ST_ON      = 3'h2,
    ST_OFF_DLY = 3'h6,
    ST_FALL    = 3'h7,
    ST_FAULT   = 3'h4
  } isos_state_t;

  // How the fault state is left
  typedef enum logic [1:0] {
    FM_LATCH  = 2'h0,
    FM_RETRY  = 2'h1,
    FM_RES_UV = 2'h2,
    FM_RES_OV = 2'h3
  } isos_fmode_t;

  // Linear word to signed fixed point with 8 fraction bits
  function automatic logic signed [31:0] isos_lin_fix(input logic [15:0] v);
    int                 e;
    logic signed [31:0] m;
    e = int'($signed(v[15:11]));
    m = {{21{v[10]}}, v[10:0]} <<< 8;
    if (e < 0)
      isos_lin_fix = m >>> (-e);
    else
      isos_lin_fix = m <<< e;
  endfunction

  // Linear time word to whole milliseconds, negatives as zero
  function automatic logic [15:0] isos_lin_ms(input logic [15:0] v);
    logic signed [31:0] f;
    f = isos_lin_fix(v);
    isos_lin_ms = (f < 0) ? 16'h0000 : f[23:8];
  endfunction

endpackage

// ===== hw/isos_ms_tick.sv
`timescale 1ns/1ps
module isos_ms_tick
  import isos_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic restart,
  output logic      tick
);

  localparam int CW = $clog2(MS_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } isos_tb_t;

  isos_tb_t st_reg;
  isos_tb_t st_next;

  // ----------------------------------------------------------------
  // Millisecond divider
  // ----------------------------------------------------------------
  // Restart realigns the phase so a delay counts whole milliseconds
  always_comb
  begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (restart)
      st_next.cnt = '0;
    else if (st_reg.cnt == CW'(MS_CYCLES - 1))
    begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end
    else
      st_next.cnt = st_reg.cnt + CW'(1);
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tick = st_reg.tick;

endmodule

// ===== hw/isos_sequencer.sv
`timescale 1ns/1ps
module isos_sequencer
  import isos_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic        cmd_word,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic             rsp_valid,
  output logic             rsp_error,
  output logic [15:0]      rsp_rdata,
  input  wire logic        on_request,
  input  wire logic        soft_off_en,
  input  wire logic        ov_fault_event,
  input  wire logic        other_fault_off,
  input  wire logic        fault_clear,
  input  wire logic        vin_valid,
  input  wire logic [15:0] vin_sample,
  input  wire logic [15:0] vout_setpoint,
  output logic [15:0]      vout_target,
  output logic             output_enable,
  output logic             output_ok_signal,
  output logic             fault_alert_line_n,
  output logic             uv_fault_flag,
  output logic             uv_warn_flag,
  output logic             ov_warn_flag
);

  typedef struct packed {
    isos_state_t state;
    isos_fmode_t fmode;
    logic [15:0] ovw;
    logic [15:0] uvw;
    logic [15:0] uvf;
    logic [7:0]  act;
    logic [15:0] pgon;
    logic [15:0] ton;
    logic [15:0] trise;
    logic [15:0] toff;
    logic [15:0] tfall;
    logic [15:0] ms_cnt;
    logic [2:0]  retry_cnt;
    logic [15:0] target;
    logic [15:0] amt;
    logic [39:0] acc;
    logic [39:0] span;
    logic        rsp_valid;
    logic        rsp_error;
    logic [15:0] rsp_rdata;
    logic        fl_uvf;
    logic        fl_uvw;
    logic        fl_ovw;
    logic        alert_n;
    logic        pg;
    logic        out_en;
  } isos_seq_t;

  isos_seq_t          st_reg;
  isos_seq_t          st_next;
  logic               ms_tick;
  logic               ms_clr;
  logic               size_ok;
  logic               go_off;
  logic [39:0]        acc_sum;
  logic signed [31:0] vin_fix;
  logic signed [31:0] ovw_fix;
  logic signed [31:0] uvw_fix;
  logic signed [31:0] uvf_fix;
  logic [15:0]        ton_ms;
  logic [15:0]        trise_ms;
  logic [15:0]        toff_ms;
  logic [15:0]        tfall_ms;
  logic [15:0]        retry_ms;
  logic               active;
  logic               uv_trip;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  isos_ms_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .restart (ms_clr),
    .tick    (ms_tick)
  );

  // ----------------------------------------------------------------
  // Decoded settings and comparisons
  // ----------------------------------------------------------------
  // Thresholds compare in a common fixed point, exact for exponents -8 to 13
  assign vin_fix  = isos_lin_fix(vin_sample);
  assign ovw_fix  = isos_lin_fix(st_reg.ovw);
  assign uvw_fix  = isos_lin_fix(st_reg.uvw);
  assign uvf_fix  = isos_lin_fix(st_reg.uvf);
  assign ton_ms   = isos_lin_ms(st_reg.ton);
  assign trise_ms = isos_lin_ms(st_reg.trise);
  assign toff_ms  = isos_lin_ms(st_reg.toff);
  assign tfall_ms = isos_lin_ms(st_reg.tfall);
  assign retry_ms = 16'(({13'h0000, st_reg.act[RTIME_HI:RTIME_LO]} + 16'h0001)
                    * 16'(RETRY_UNIT_MS));
  assign active   = st_reg.state inside {ST_ON_DLY, ST_RISE, ST_ON, ST_OFF_DLY, ST_FALL};
  assign uv_trip  = active && vin_valid && (vin_fix < uvf_fix);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next           = st_reg;
    ms_clr            = 1'b0;
    go_off            = 1'b0;
    size_ok           = 1'b0;
    acc_sum           = st_reg.acc + 40'(st_reg.amt);
    st_next.rsp_valid = 1'b0;
    st_next.rsp_error = 1'b0;
    if (ms_tick && st_reg.ms_cnt != 16'hffff)
      st_next.ms_cnt = st_reg.ms_cnt + 16'h0001;

    // Action is byte wide, everything else word wide
    unique case (cmd_code)
      CMD_OV_WARN, CMD_UV_WARN, CMD_UV_FLT, CMD_PG_ON,
      CMD_TON_DLY, CMD_TURN_ON_RAMP_TIME, CMD_TOFF_DLY, CMD_TURN_OFF_RAMP_TIME:
        size_ok = cmd_word;
      CMD_UV_ACT:
        size_ok = !cmd_word;
      default:
        size_ok = 1'b0;
    endcase

    // Command access; wrong size or unknown code answers with error
    if (cmd_valid)
    begin
      st_next.rsp_valid = 1'b1;
      st_next.rsp_error = !size_ok;
      st_next.rsp_rdata = 16'h0000;
      if (size_ok && cmd_write)
      begin
        unique case (cmd_code)
          CMD_OV_WARN:   st_next.ovw   = cmd_wdata;
          CMD_UV_WARN:   st_next.uvw   = cmd_wdata;
          CMD_UV_FLT:    st_next.uvf   = cmd_wdata;
          CMD_UV_ACT:    st_next.act   = cmd_wdata[7:0];
          CMD_PG_ON:     st_next.pgon  = cmd_wdata;
          CMD_TON_DLY:   st_next.ton   = cmd_wdata;
          CMD_TURN_ON_RAMP_TIME:  st_next.trise = cmd_wdata;
          CMD_TOFF_DLY:  st_next.toff  = cmd_wdata;
          default:       st_next.tfall = cmd_wdata;
        endcase
      end
      else if (size_ok)
      begin
        unique case (cmd_code)
          CMD_OV_WARN:   st_next.rsp_rdata = st_reg.ovw;
          CMD_UV_WARN:   st_next.rsp_rdata = st_reg.uvw;
          CMD_UV_FLT:    st_next.rsp_rdata = st_reg.uvf;
          CMD_UV_ACT:    st_next.rsp_rdata = {8'h00, st_reg.act};
          CMD_PG_ON:     st_next.rsp_rdata = st_reg.pgon;
          CMD_TON_DLY:   st_next.rsp_rdata = st_reg.ton;
          CMD_TURN_ON_RAMP_TIME:  st_next.rsp_rdata = st_reg.trise;
          CMD_TOFF_DLY:  st_next.rsp_rdata = st_reg.toff;
          default:       st_next.rsp_rdata = st_reg.tfall;
        endcase
      end
    end

    // Flags: clear first so a same-cycle event still lands
    if (fault_clear)
    begin
      st_next.fl_uvf = 1'b0;
      st_next.fl_uvw = 1'b0;
      st_next.fl_ovw = 1'b0;
    end
    if (vin_valid && vin_fix > ovw_fix)
      st_next.fl_ovw = 1'b1;
    if (vin_valid && vin_fix < uvw_fix)
      st_next.fl_uvw = 1'b1;
    if (uv_trip)
      st_next.fl_uvf = 1'b1;

    // Sequencer
    unique case (st_reg.state)
      ST_OFF:
        if (on_request)
        begin
          st_next.state     = ST_ON_DLY;
          st_next.retry_cnt = st_reg.act[RETRY_HI:RETRY_LO];
          ms_clr            = 1'b1;
        end
      ST_ON_DLY:
        // Same delay whatever source raised the request
        if (!on_request)
          st_next.state = ST_OFF;
        else if (st_reg.ms_cnt >= ton_ms)
        begin
          st_next.state = ST_RISE;
          st_next.amt   = vout_setpoint;
          st_next.acc   = '0;
          st_next.span  = 40'(trise_ms) * 40'(MS_CYCLES);
        end
      ST_RISE:
        if (!on_request)
          go_off = 1'b1;
        else if (st_reg.target >= st_reg.amt)
          st_next.state = ST_ON;
        else if (st_reg.span == '0)
          st_next.target = st_reg.amt;
        else if (acc_sum >= st_reg.span)
        begin
          // One code per carry keeps the ramp even
          st_next.acc    = acc_sum - st_reg.span;
          st_next.target = st_reg.target + 16'h0001;
        end
        else
          st_next.acc = acc_sum;
      ST_ON:
        if (!on_request)
          go_off = 1'b1;
      ST_OFF_DLY:
        if (st_reg.ms_cnt >= toff_ms)
        begin
          st_next.state = ST_FALL;
          st_next.amt   = st_reg.target;
          st_next.acc   = '0;
          // Soft-off disabled gives a zero-length fall
          st_next.span  = soft_off_en ? 40'(tfall_ms) * 40'(MS_CYCLES) : '0;
        end
      ST_FALL:
        if (st_reg.target == 16'h0000)
          st_next.state = ST_OFF;
        else if (st_reg.span == '0)
          st_next.target = 16'h0000;
        else if (acc_sum >= st_reg.span)
        begin
          st_next.acc    = acc_sum - st_reg.span;
          st_next.target = st_reg.target - 16'h0001;
        end
        else
          st_next.acc = acc_sum;
      ST_FAULT:
        if (!on_request || fault_clear)
          st_next.state = ST_OFF;
        else
        begin
          unique case (st_reg.fmode)
            FM_RETRY:
              if (st_reg.ms_cnt >= retry_ms)
              begin
                st_next.state = ST_ON_DLY;
                ms_clr        = 1'b1;
                if (st_reg.retry_cnt != RETRY_FOREVER)
                  st_next.retry_cnt = st_reg.retry_cnt - 3'h1;
              end
            FM_RES_UV:
              if (vin_valid && vin_fix > uvw_fix)
              begin
                st_next.state = ST_ON_DLY;
                ms_clr        = 1'b1;
              end
            FM_RES_OV:
              if (vin_valid && vin_fix < ovw_fix)
              begin
                st_next.state = ST_ON_DLY;
                ms_clr        = 1'b1;
              end
            FM_LATCH:
              st_next.state = ST_FAULT;
          endcase
        end
      default:
        st_next.state = ST_OFF;
    endcase

    // Disable: zero turn-off delay skips both delay and ramp
    if (go_off)
    begin
      if (toff_ms == 16'h0000)
      begin
        st_next.state  = ST_OFF;
        st_next.target = 16'h0000;
      end
      else
      begin
        st_next.state = ST_OFF_DLY;
        ms_clr        = 1'b1;
      end
    end

    // Faults override the sequencer; actions 0x only flag and alert
    if (uv_trip && st_reg.act[RESP_HI])
    begin
      st_next.state  = ST_FAULT;
      st_next.target = 16'h0000;
      ms_clr         = 1'b1;
      if (st_reg.act[RESP_LO])
        st_next.fmode = FM_RES_UV;
      else if (st_reg.retry_cnt == RETRY_NONE)
        st_next.fmode = FM_LATCH;
      else
        st_next.fmode = FM_RETRY;
    end
    if (ov_fault_event && active)
    begin
      st_next.state  = ST_FAULT;
      st_next.target = 16'h0000;
      st_next.fmode  = FM_RES_OV;
    end
    // Another shutdown ends any retry run
    if (other_fault_off)
    begin
      st_next.state  = ST_FAULT;
      st_next.target = 16'h0000;
      st_next.fmode  = FM_LATCH;
    end

    if (ms_clr)
      st_next.ms_cnt = 16'h0000;
    st_next.out_en  = st_next.state inside {ST_RISE, ST_ON, ST_OFF_DLY, ST_FALL};
    st_next.pg      = st_next.out_en && (st_next.target >= st_reg.pgon);
    st_next.alert_n = !(st_next.fl_uvf || st_next.fl_uvw || st_next.fl_ovw);
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg         <= '0;
      st_reg.state   <= ST_OFF;
      st_reg.ovw     <= RST_OV_WARN;
      st_reg.uvw     <= RST_UV_WARN;
      st_reg.uvf     <= RST_UV_FLT;
      st_reg.act     <= RST_UV_ACT;
      st_reg.pgon    <= RST_PG_ON;
      st_reg.ton     <= RST_TIME;
      st_reg.trise   <= RST_TIME;
      st_reg.toff    <= RST_TIME;
      st_reg.tfall   <= RST_TIME;
      st_reg.alert_n <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rsp_valid          = st_reg.rsp_valid;
  assign rsp_error          = st_reg.rsp_error;
  assign rsp_rdata          = st_reg.rsp_rdata;
  assign vout_target        = st_reg.target;
  assign output_enable      = st_reg.out_en;
  assign output_ok_signal   = st_reg.pg;
  assign fault_alert_line_n = st_reg.alert_n;
  assign uv_fault_flag      = st_reg.fl_uvf;
  assign uv_warn_flag       = st_reg.fl_uvw;
  assign ov_warn_flag       = st_reg.fl_ovw;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_uv_trip;
    uv_trip && st_reg.act[RESP_HI];
  endsequence

  sequence s_dark;
    st_reg.state == ST_FAULT && st_reg.target == 16'h0000 && !st_reg.out_en;
  endsequence

  a_uv_retry_off: assert property (
    (s_uv_trip and st_reg.act[RESP_LO] == 1'b0) |=> s_dark)
    else $error("retry mode did not cut output");
  a_uv_resume_off: assert property (
    (s_uv_trip and st_reg.act[RESP_LO] == 1'b1 && !other_fault_off && !ov_fault_event)
    |=> s_dark ##0 st_reg.fmode == FM_RES_UV)
    else $error("resume mode did not cut output");
  a_uv_alert_low: assert property (
    uv_trip |=> !fault_alert_line_n && uv_fault_flag)
    else $error("undervoltage fault gave no alert");
  a_latch_hold: assert property (
    (st_reg.state == ST_FAULT && st_reg.fmode == FM_LATCH && on_request && !fault_clear)
    |=> st_reg.state == ST_FAULT [*1])
    else $error("latched fault restarted");
  a_retry_step: assert property (
    (st_reg.state == ST_FAULT && st_next.state == ST_ON_DLY
     && st_reg.fmode == FM_RETRY && st_reg.retry_cnt != RETRY_FOREVER)
    |=> st_reg.retry_cnt == $past(st_reg.retry_cnt) - 3'h1)
    else $error("retry count not spent");
  a_retry_wait: assert property (
    (st_reg.state == ST_FAULT && st_next.state == ST_ON_DLY && st_reg.fmode == FM_RETRY)
    |-> st_reg.ms_cnt == retry_ms)
    else $error("retry wait wrong length");
  a_on_wait: assert property (
    (st_reg.state == ST_ON_DLY && st_next.state == ST_RISE) |-> st_reg.ms_cnt == ton_ms)
    else $error("turn-on delay wrong length");
  a_fast_off: assert property (
    (st_reg.state == ST_ON && !on_request && toff_ms == 16'h0000
     && !uv_trip && !ov_fault_event && !other_fault_off)
    |=> st_reg.state == ST_OFF && vout_target == 16'h0000)
    else $error("zero turn-off delay not immediate");
  a_rise_mono: assert property (
    (st_reg.state == ST_RISE ##1 st_reg.state == ST_RISE) |-> vout_target >= $past(vout_target))
    else $error("rise ramp went down");
  a_pg_follow: assert property (
    output_enable && vout_target >= st_reg.pgon && $stable(st_reg.pgon)
    |-> output_ok_signal)
    else $error("power-good missing");
  a_size_err: assert property (
    cmd_valid && cmd_code == CMD_UV_ACT && cmd_word |=> rsp_valid && rsp_error)
    else $error("word access to byte command accepted");

endmodule

// ===== verification/isos_host_model.sv
`timescale 1ns/1ps
// ------------------------------
// Command host model
// ------------------------------
module isos_host_model
(
  input  wire logic        clk_sys,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic             cmd_word,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_error,
  input  wire logic [15:0] rsp_rdata
);
  // Quiet bus until the first command
  initial
  begin
    cmd_valid = 1'b0;
    {cmd_write, cmd_word, cmd_code, cmd_wdata} = '0;
  end
  // One beat; the answer is registered on the taking edge
  task automatic xfer(input logic w, input logic wd, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] r, output logic e);
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b1;
    {cmd_write, cmd_word, cmd_code, cmd_wdata} = {w, wd, c, d};
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
    // Released lines show the inverse, so stale data never looks valid
    {cmd_write, cmd_word, cmd_code, cmd_wdata} = ~{w, wd, c, d};
    r = rsp_rdata;
    e = rsp_valid ? rsp_error : 1'bx;
  endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
module tb_top
  import isos_pkg::*;
;
  // ------------------------------
  // Signals and instances
  // ------------------------------
  typedef struct packed {logic w; logic wd; logic [7:0] c; logic [15:0] d;
                         logic [15:0] r; logic e;} isos_row_t;
  logic        clk_sys = 1'b0, resetn = 1'b0, on_request = 1'b0, soft_off_en = 1'b1;
  logic        ov_fault_event = 1'b0, other_fault_off = 1'b0, fault_clear = 1'b0;
  logic        vin_valid = 1'b0, cmd_valid, cmd_write, cmd_word, rsp_valid, rsp_error;
  logic        output_enable, output_ok_signal, fault_alert_line_n, e;
  logic        uv_fault_flag, uv_warn_flag, ov_warn_flag;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, rsp_rdata, vout_target, r;
  logic [15:0] vin_sample = 16'h000c, vout_setpoint = 16'h0014;
  int          fails = 0, n_compared = 0, n;
  // Plain command traffic: reset values, writes, refusals, read-back
  isos_row_t   rows [19] = '{'{0,1,8'h57,16'h0,16'h03ff,0}, '{0,0,8'h5a,16'h0,16'h0080,0},
    '{1,1,8'h57,16'h000e,16'h0,0}, '{1,1,8'h58,16'h000a,16'h0,0},
    '{1,1,8'h59,16'h0008,16'h0,0}, '{1,1,8'h5e,16'h0010,16'h0,0},
    '{1,1,8'h60,16'h001e,16'h0,0}, '{1,1,8'h61,16'h0005,16'h0,0},
    '{1,1,8'h64,16'h0000,16'h0,0}, '{1,1,8'h65,16'h0002,16'h0,0},
    '{1,0,8'h5a,16'h0088,16'h0,0}, '{1,1,8'h5a,16'h00c0,16'h0,1},
    '{1,0,8'h57,16'h0055,16'h0,1}, '{1,1,8'h55,16'h1234,16'h0,1},
    '{0,1,8'h57,16'h0,16'h000e,0}, '{0,1,8'h59,16'h0,16'h0008,0},
    '{0,1,8'h5e,16'h0,16'h0010,0}, '{0,1,8'h60,16'h0,16'h001e,0},
    '{0,0,8'h5a,16'h0,16'h0088,0}};
  // 100 MHz
  always #5 clk_sys = ~clk_sys;
  isos_host_model u_isos_host_model (.clk_sys, .cmd_valid, .cmd_write, .cmd_word,
    .cmd_code, .cmd_wdata, .rsp_valid, .rsp_error, .rsp_rdata);
  // Short millisecond so the long delays fit the run; ramps step one code per
  // clock at most, so the setpoint stays no higher than either ramp span
  isos_sequencer #(.MS_CYCLES(10)) u_isos_sequencer (.clk_sys, .resetn, .cmd_valid,
    .cmd_write, .cmd_word, .cmd_code, .cmd_wdata, .rsp_valid, .rsp_error, .rsp_rdata,
    .on_request, .soft_off_en, .ov_fault_event, .other_fault_off, .fault_clear,
    .vin_valid, .vin_sample, .vout_setpoint, .vout_target, .output_enable,
    .output_ok_signal, .fault_alert_line_n, .uv_fault_flag, .uv_warn_flag, .ov_warn_flag);
  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic final_report();
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic give_up();
    fails++;
    final_report();
  endtask
  // Inputs always move 1 ns after the edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_oe(input logic v, input int lim);
    n = 0;
    while (output_enable !== v)
    begin
      tick(1);
      n++;
      if (n > lim) give_up();
    end
  endtask
  task automatic meas(input logic [15:0] v);
    vin_sample = v;
    vin_valid = 1'b1;
    tick(1);
    vin_valid = 1'b0;
  endtask
  // Good input first, else the clear could be undone at once
  task automatic clear();
    meas(16'h000c);
    fault_clear = 1'b1;
    tick(1);
    fault_clear = 1'b0;
  endtask
  task automatic stay_off(input int k);
    e = 1'b0;
    repeat (k)
    begin
      tick(1);
      e |= output_enable;
    end
  endtask
  // Track every ramp step for a downward move
  task automatic ramp_up();
    r = 16'h0000;
    e = 1'b1;
    n = 0;
    while (vout_target !== vout_setpoint)
    begin
      tick(1);
      e &= (vout_target >= r);
      r = vout_target;
      n++;
      if (n > 200) give_up();
    end
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin
    tick(5);
    `CHK({output_enable, fault_alert_line_n}, 2'b01)
    resetn = 1'b1;
    foreach (rows[i])
    begin
      u_isos_host_model.xfer(rows[i].w, rows[i].wd, rows[i].c, rows[i].d, r, e);
      `CHK(e, rows[i].e)
      `CHK(r, rows[i].r)
    end
    on_request = 1'b1; // 30 ms delay programmed above
    wait_oe(1'b1, 320);
    `CHK(n inside {[300:306]}, 1'b1)
    ramp_up();
    `CHK(n inside {[45:55]}, 1'b1)
    `CHK(e, 1'b1)
    `CHK(output_ok_signal, 1'b1)
    meas(16'h0009);
    tick(2);
    `CHK({uv_warn_flag, fault_alert_line_n, output_enable}, 3'b101)
    clear();
    on_request = 1'b0;
    wait_oe(1'b0, 2);
    `CHK(vout_target, 16'h0000)
    u_isos_host_model.xfer(1'b1, 1'b1, 8'h64, 16'h0004, r, e);
    on_request = 1'b1;
    wait_oe(1'b1, 320);
    ramp_up();
    on_request = 1'b0;
    wait_oe(1'b0, 80);
    `CHK(n inside {[57:66]}, 1'b1)
    on_request = 1'b1;
    wait_oe(1'b1, 320);
    meas(16'h0007);
    wait_oe(1'b0, 3);
    tick(1);
    `CHK({uv_fault_flag, fault_alert_line_n}, 2'b10)
    wait_oe(1'b1, 700);
    `CHK(n inside {[646:662]}, 1'b1)
    meas(16'h0007);
    stay_off(1000);
    `CHK(e, 1'b0)
    u_isos_host_model.xfer(1'b1, 1'b0, 8'h5a, 16'h0080, r, e);
    clear();
    wait_oe(1'b1, 330);
    meas(16'h0007);
    stay_off(800);
    `CHK(e, 1'b0)
    u_isos_host_model.xfer(1'b1, 1'b0, 8'h5a, 16'h00c0, r, e);
    clear();
    wait_oe(1'b1, 330);
    meas(16'h0007);
    wait_oe(1'b0, 3);
    meas(16'h000b);
    wait_oe(1'b1, 330);
    `CHK(n <= 306, 1'b1)
    meas(16'h000f);
    `CHK({ov_warn_flag, output_enable}, 2'b11)
    ov_fault_event = 1'b1;
    tick(1);
    ov_fault_event = 1'b0;
    meas(16'h000e);
    `CHK(output_enable, 1'b0)
    meas(16'h000d);
    wait_oe(1'b1, 330);
    `CHK(n inside {[300:306]}, 1'b1)
    // Soft-off off: delay still counted, fall takes no time
    ramp_up();
    soft_off_en = 1'b0;
    on_request = 1'b0;
    wait_oe(1'b0, 80);
    `CHK(n inside {[43:47]}, 1'b1)
    `CHK(vout_target, 16'h0000)
    soft_off_en = 1'b1;
    // Count 7 never runs out; another fault, a clear or a dropped request stops it
    u_isos_host_model.xfer(1'b1, 1'b0, 8'h5a, 16'h00b8, r, e);
    on_request = 1'b1;
    wait_oe(1'b1, 330);
    repeat (8)
    begin
      meas(16'h0007);
      wait_oe(1'b1, 700);
      `CHK(n inside {[646:662]}, 1'b1)
    end
    meas(16'h0007);
    other_fault_off = 1'b1;
    tick(1);
    other_fault_off = 1'b0;
    stay_off(400);
    `CHK(e, 1'b0)
    resetn = 1'b0;
    tick(1);
    `CHK({output_enable, fault_alert_line_n}, 2'b01)
    resetn = 1'b1;
    u_isos_host_model.xfer(1'b0, 1'b0, 8'h5a, 16'h0000, r, e);
    `CHK(r, 16'h0080)
    final_report();
  end
endmodule
